// File: rtl/slot_hp_pkg.sv
package slot_hp_pkg;
	typedef logic [11:0] addr_t;
	localparam addr_t CAP_OFS = 12'h0d4;
	localparam addr_t CTL_OFS = 12'h0d8;
	localparam int CAP_ABTN = 0;
	localparam int CAP_PCTL = 1;
	localparam int CAP_AIND = 3;
	localparam int CAP_PIND = 4;
	localparam int CAP_SURP = 5;
	localparam int CAP_HPC = 6;
	localparam int CAP_PLV = 7;
	localparam int CAP_PLS = 15;
	localparam int CAP_PSN = 19;
	localparam logic [31:0] CAP_RST = 32'h0000_0000;
	localparam logic [31:0] CAP_IMPL = 32'hfff9_fffb;
	localparam logic [31:0] CAP_RW = 32'h0001_ff80;
	localparam int CTL_ABP = 0;
	localparam int CTL_PFD = 1;
	localparam int CTL_PDC = 3;
	localparam int CTL_CC = 4;
	localparam int CTL_HPIE = 5;
	localparam int CTL_AIC = 6;
	localparam int CTL_PIC = 8;
	localparam int CTL_PCC = 10;
	localparam int CTL_DLL = 12;
	localparam logic [15:0] CTL_RST = 16'h03c0;
	localparam logic [15:0] CTL_IMPL = 16'h17fb;
	localparam logic [1:0] IND_RSVD = 2'h0;
	localparam logic [1:0] IND_ON = 2'h1;
	localparam logic [1:0] IND_BLINK = 2'h2;
	localparam logic [7:0] MSG_SPL = 8'h50;
	localparam logic [7:0] MSG_ATTN = 8'h40;
	localparam logic [7:0] MSG_PWR = 8'h44;
	localparam logic [7:0] MSG_ON = 8'h01;
	localparam logic [7:0] MSG_BLINK = 8'h03;

	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : be_mask

	// Off, and the reserved code, map onto the group base
	function automatic logic [7:0] ind_msg(input logic [1:0] ind, input logic [7:0] base);
		case (ind)
			IND_ON: ind_msg = base | MSG_ON;
			IND_BLINK: ind_msg = base | MSG_BLINK;
			default: ind_msg = base;
		endcase
	endfunction : ind_msg
endpackage : slot_hp_pkg

// File: rtl/msg_sender.sv
module msg_sender (
	input wire logic mclk, // Core clock
	input wire logic rst_n, // Reset, active low
	input wire logic plim_req, // Power limit write seen
	input wire logic attn_req, // Attention field written
	input wire logic pind_req, // Power indicator written
	input wire logic [1:0] attn_ind, // Current attention code
	input wire logic [1:0] pwr_ind, // Current power code
	input wire logic [9:0] plimit, // Scale and value
	input wire logic msg_ready, // Message taken
	output logic msg_valid, // Message offered
	output logic [7:0] msg_code, // Message code
	output logic [9:0] msg_data // Message payload
);
	import slot_hp_pkg::*;
	typedef enum logic [1:0] {MS_IDLE = 2'b01, MS_SEND = 2'b10} ms_e;
	typedef struct packed {
		ms_e st;
		logic [2:0] pend;
		logic [7:0] code;
		logic [9:0] data;
	} ms_s;
	ms_s q, d;
	logic [2:0] take;

	always_comb begin
		d = q;
		take = 3'h0;
		case (q.st)
			MS_IDLE: d.st = MS_IDLE;
			MS_SEND: d.st = msg_ready ? MS_IDLE : MS_SEND;
			default: d.st = MS_IDLE;
		endcase
		if (d.st == MS_IDLE && q.pend[0]) begin
			take = 3'h1;
			d = '{st: MS_SEND, pend: q.pend, code: MSG_SPL, data: plimit};
		end else if (d.st == MS_IDLE && q.pend[1]) begin
			take = 3'h2;
			d = '{st: MS_SEND, pend: q.pend, code: ind_msg(attn_ind, MSG_ATTN), data: 10'h000};
		end else if (d.st == MS_IDLE && q.pend[2]) begin
			take = 3'h4;
			d = '{st: MS_SEND, pend: q.pend, code: ind_msg(pwr_ind, MSG_PWR), data: 10'h000};
		end
		// A new write beats the launch of an older one
		d.pend = (q.pend & ~take) | {pind_req, attn_req, plim_req};
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{st: MS_IDLE, default: '0};
		end else begin
			q <= d;
		end
	end

	assign msg_valid = q.st == MS_SEND;
	assign msg_code = q.code;
	assign msg_data = q.data;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence stall_s;
		msg_valid && !msg_ready;
	endsequence
	msg_hold_a:
		assert property (stall_s |=> msg_valid && $stable(msg_code) && $stable(msg_data))
		else $error("message changed while stalled");
	// Only from a quiet sender: an older pending indicator message would launch first
	plim_send_a:
		assert property (plim_req && !msg_valid && q.pend == 3'h0
			|-> ##[1:2] (msg_valid && msg_code == MSG_SPL))
		else $error("power limit message missing");
endmodule : msg_sender

// File: rtl/event_gate.sv
module event_gate (
	input wire logic mclk, // Core clock
	input wire logic rst_n, // Reset, active low
	input wire logic [15:0] ctl, // Slot control word
	input wire logic ev_abtn, // Button pressed pulse
	input wire logic ev_pfault, // Power fault pulse
	input wire logic ev_pdc, // Presence changed pulse
	input wire logic ev_cmd, // Command done pulse
	input wire logic dl_active, // DL machine active
	input wire logic dllsc_clr, // Clear changed flag
	output logic hp_int, // Interrupt pulse
	output logic wake, // Wake pulse
	output logic link_active, // Link active bit
	output logic dllsc_flag // DL state changed flag
);
	import slot_hp_pkg::*;
	typedef struct packed {
		logic link;
		logic dllsc;
		logic irq;
		logic wake;
	} eg_s;
	eg_s q, d;
	logic chg, ev;

	always_comb begin
		d = q;
		d.link = dl_active;
		chg = dl_active ^ q.link;
		d.dllsc = (q.dllsc & ~dllsc_clr) | chg;
		ev = (ctl[CTL_ABP] & ev_abtn) | (ctl[CTL_PFD] & ev_pfault) | (ctl[CTL_PDC] & ev_pdc);
		d.wake = ev;
		d.irq = ctl[CTL_HPIE] & (ev | (ctl[CTL_CC] & ev_cmd) | (ctl[CTL_DLL] & chg));
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign hp_int = q.irq;
	assign wake = q.wake;
	assign link_active = q.link;
	assign dllsc_flag = q.dllsc;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	irq_gate_a:
		assert property (hp_int |-> $past(ctl[CTL_HPIE]))
		else $error("interrupt without master enable");
	dll_set_a:
		assert property (dl_active != link_active |=> dllsc_flag && link_active == $past(dl_active))
		else $error("link change not flagged");
	cmd_irq_a:
		assert property (ctl[CTL_HPIE] && ctl[CTL_CC] && ev_cmd |=> hp_int && !wake || $past(ev))
		else $error("command done interrupt missing");
endmodule : event_gate

// File: rtl/slot_hp_regs.sv
module slot_hp_regs (
	input wire logic mclk, // Core clock
	input wire logic rst_n, // Fundamental reset
	input wire logic cfg_wr, // Config write strobe
	input wire logic cfg_rd, // Config read strobe
	input wire slot_hp_pkg::addr_t cfg_addr, // Byte address
	input wire logic [3:0] cfg_be, // Byte enables
	input wire logic [31:0] cfg_wdata, // Write data
	output logic [31:0] cfg_rdata, // Read data
	output logic cfg_rvalid, // Read answer pulse
	input wire logic ld_wr, // Default load strobe
	input wire logic [31:0] ld_data, // Capability defaults
	input wire logic ev_abtn, // Button pressed pulse
	input wire logic ev_pfault, // Power fault pulse
	input wire logic ev_pdc, // Presence changed pulse
	input wire logic ev_cmd, // Command done pulse
	input wire logic dl_active, // DL machine active
	input wire logic dllsc_clr, // Clear changed flag
	input wire logic msg_ready, // Message taken
	output logic msg_valid, // Message offered
	output logic [7:0] msg_code, // Message code
	output logic [9:0] msg_data, // Message payload
	output logic hp_int, // Interrupt pulse
	output logic wake, // Wake pulse
	output logic link_active, // Link active bit
	output logic dllsc_flag, // DL state changed flag
	output logic [1:0] attn_ind, // Attention indicator
	output logic [1:0] pwr_ind, // Power indicator
	output logic slot_power_off // Slot power off
);
	import slot_hp_pkg::*;
	typedef struct packed {
		logic [31:0] cap;
		logic [15:0] ctl;
		logic [31:0] rdata;
		logic rvalid;
		logic plim_req;
		logic attn_req;
		logic pind_req;
	} regs_s;
	regs_s q, d;
	logic cap_hit, ctl_hit, sw_cap_wr;
	logic [31:0] wmask, capm;
	logic [15:0] ctlm;

	assign cap_hit = cfg_addr == CAP_OFS;
	assign ctl_hit = cfg_addr == CTL_OFS;
	assign sw_cap_wr = cfg_wr && cap_hit && !ld_wr;
	assign wmask = be_mask(cfg_be);
	assign capm = wmask & CAP_RW;
	assign ctlm = wmask[15:0] & CTL_IMPL;

	always_comb begin
		d = q;
		d.rvalid = cfg_rd;
		d.plim_req = 1'b0;
		d.attn_req = 1'b0;
		d.pind_req = 1'b0;
		if (ld_wr) begin
			d.cap = ld_data & CAP_IMPL;
		end
		if (cfg_wr && cap_hit) begin
			d.cap = (d.cap & ~capm) | (cfg_wdata & capm);
			d.plim_req = |capm;
		end
		if (cfg_wr && ctl_hit) begin
			d.ctl = (q.ctl & ~ctlm) | (cfg_wdata[15:0] & ctlm);
			d.attn_req = ctlm[CTL_AIC] && cfg_wdata[CTL_AIC +: 2] != IND_RSVD;
			d.pind_req = ctlm[CTL_PIC] && cfg_wdata[CTL_PIC +: 2] != IND_RSVD;
		end
		if (cfg_rd) begin
			if (cap_hit) begin
				d.rdata = q.cap & CAP_IMPL;
			end else if (ctl_hit) begin
				d.rdata = {16'h0000, q.ctl & CTL_IMPL};
			end else begin
				d.rdata = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{cap: CAP_RST, ctl: CTL_RST, default: '0};
		end else begin
			q <= d;
		end
	end

	assign cfg_rdata = q.rdata;
	assign cfg_rvalid = q.rvalid;
	assign attn_ind = q.ctl[CTL_AIC +: 2];
	assign pwr_ind = q.ctl[CTL_PIC +: 2];
	assign slot_power_off = q.ctl[CTL_PCC];

	msg_sender u_msg (
		.mclk(mclk),
		.rst_n(rst_n),
		.plim_req(q.plim_req),
		.attn_req(q.attn_req),
		.pind_req(q.pind_req),
		.attn_ind(q.ctl[CTL_AIC +: 2]),
		.pwr_ind(q.ctl[CTL_PIC +: 2]),
		.plimit(q.cap[CAP_PLV +: 10]),
		.msg_ready(msg_ready),
		.msg_valid(msg_valid),
		.msg_code(msg_code),
		.msg_data(msg_data)
	);

	event_gate u_evt (
		.mclk(mclk),
		.rst_n(rst_n),
		.ctl(q.ctl),
		.ev_abtn(ev_abtn),
		.ev_pfault(ev_pfault),
		.ev_pdc(ev_pdc),
		.ev_cmd(ev_cmd),
		.dl_active(dl_active),
		.dllsc_clr(dllsc_clr),
		.hp_int(hp_int),
		.wake(wake),
		.link_active(link_active),
		.dllsc_flag(dllsc_flag)
	);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	ro_abtn_a:
		assert property (sw_cap_wr |=> $stable(q.cap[CAP_ABTN]))
		else $error("button flag written");
	ro_pctl_a:
		assert property (sw_cap_wr |=> $stable(q.cap[CAP_PCTL]))
		else $error("power controller flag written");
	ro_aind_a:
		assert property (sw_cap_wr |=> $stable(q.cap[CAP_AIND]))
		else $error("attention indicator flag written");
	ro_pind_a:
		assert property (sw_cap_wr |=> $stable(q.cap[CAP_PIND]))
		else $error("power indicator flag written");
	ro_surp_a:
		assert property (sw_cap_wr |=> $stable(q.cap[CAP_SURP]))
		else $error("surprise flag written");
	ro_hpc_a:
		assert property (sw_cap_wr |=> $stable(q.cap[CAP_HPC]))
		else $error("capable flag written");
	ro_psn_a:
		assert property (sw_cap_wr |=> $stable(q.cap[31:CAP_PSN]))
		else $error("slot number written");
	ld_load_a:
		assert property (ld_wr && !(cfg_wr && cap_hit) |=> q.cap == ($past(ld_data) & CAP_IMPL))
		else $error("loader value not taken");

	sequence cap_rd_s;
		cfg_rd && cap_hit && !ld_wr && !cfg_wr;
	endsequence
	ld_seen_a:
		assert property (ld_wr && !(cfg_wr && cap_hit) ##1 cap_rd_s
			|=> cfg_rdata == ($past(ld_data, 2) & CAP_IMPL))
		else $error("loaded default not visible");
	plv_wr_a:
		assert property (sw_cap_wr && cfg_be[1:0] == 2'h3
			|=> q.cap[CAP_PLV +: 8] == $past(cfg_wdata[CAP_PLV +: 8]))
		else $error("limit value not stored");
	pls_wr_a:
		assert property (sw_cap_wr && cfg_be[2:1] == 2'h3
			|=> q.cap[CAP_PLS +: 2] == $past(cfg_wdata[CAP_PLS +: 2]))
		else $error("limit scale not stored");

	sequence plim_wr_s;
		cfg_wr && cap_hit && (cfg_be[0] || cfg_be[1] || cfg_be[2]);
	endsequence
	plim_req_a:
		assert property (plim_wr_s |=> q.plim_req)
		else $error("limit write without message");
	plim_none_a:
		assert property (!(cfg_wr && cap_hit) |=> !q.plim_req)
		else $error("spurious limit message");

	sequence ctl_wr0_s;
		cfg_wr && ctl_hit && cfg_be[0];
	endsequence
	sequence ctl_wr1_s;
		cfg_wr && ctl_hit && cfg_be[1];
	endsequence
	abp_en_a:
		assert property (ctl_wr0_s |=> q.ctl[CTL_ABP] == $past(cfg_wdata[CTL_ABP]))
		else $error("button enable not stored");
	pfd_en_a:
		assert property (ctl_wr0_s |=> q.ctl[CTL_PFD] == $past(cfg_wdata[CTL_PFD]))
		else $error("fault enable not stored");
	pdc_en_a:
		assert property (ctl_wr0_s |=> q.ctl[CTL_PDC] == $past(cfg_wdata[CTL_PDC]))
		else $error("presence enable not stored");
	cc_en_a:
		assert property (ctl_wr0_s |=> q.ctl[CTL_CC] == $past(cfg_wdata[CTL_CC]))
		else $error("command enable not stored");
	hpie_a:
		assert property (ctl_wr0_s ##1 ev_abtn && q.ctl[CTL_ABP]
			|=> hp_int == $past(q.ctl[CTL_HPIE]))
		else $error("master gate wrong");
	abp_path_a:
		assert property (ev_abtn && q.ctl[CTL_ABP] |=> wake)
		else $error("button wake missing");
	pfd_path_a:
		assert property (ev_pfault && q.ctl[CTL_PFD] && q.ctl[CTL_HPIE] |=> hp_int && wake)
		else $error("fault event lost");
	pdc_path_a:
		assert property (ev_pdc && q.ctl[CTL_PDC] && q.ctl[CTL_HPIE] |=> hp_int && wake)
		else $error("presence event lost");
	attn_drv_a:
		assert property (ctl_wr0_s |=> attn_ind == $past(cfg_wdata[CTL_AIC +: 2]))
		else $error("attention indicator not driven");
	attn_msg_a:
		assert property (ctl_wr0_s |=> q.attn_req == ($past(cfg_wdata[CTL_AIC +: 2]) != IND_RSVD))
		else $error("attention message wrong");
	pwr_drv_a:
		assert property (ctl_wr1_s |=> pwr_ind == $past(cfg_wdata[CTL_PIC +: 2]))
		else $error("power indicator not driven");
	pwr_msg_a:
		assert property (ctl_wr1_s |=> q.pind_req == ($past(cfg_wdata[CTL_PIC +: 2]) != IND_RSVD))
		else $error("power indicator message wrong");
	pcc_a:
		assert property (ctl_wr1_s |=> slot_power_off == $past(cfg_wdata[CTL_PCC]))
		else $error("slot power command wrong");
	dll_en_a:
		assert property (ctl_wr1_s |=> q.ctl[CTL_DLL] == $past(cfg_wdata[CTL_DLL]))
		else $error("link change enable not stored");
	dll_path_a:
		assert property (dl_active != link_active && q.ctl[CTL_DLL] && q.ctl[CTL_HPIE] |=> hp_int)
		else $error("link change not notified");
	rsvd_cap_a:
		assert property (cfg_rvalid && $past(cap_hit) |-> cfg_rdata[2] == 1'b0
			&& cfg_rdata[18:17] == 2'h0)
		else $error("reserved capability bit reads one");
	rsvd_ctl_a:
		assert property (cfg_rvalid && $past(ctl_hit) |-> (cfg_rdata & ~{16'h0000, CTL_IMPL}) == 0)
		else $error("reserved control bit reads one");
	rsvd_hold_a:
		assert property ((q.cap & ~CAP_IMPL) == 0 && (q.ctl & ~CTL_IMPL) == 0)
		else $error("reserved state bit set");
	rd_back_a:
		assert property (cfg_rd && ctl_hit |=> cfg_rvalid && cfg_rdata[15:0] == $past(q.ctl))
		else $error("control readback wrong");
	link_a:
		assert property (dl_active [*2] |-> link_active ##1 link_active)
		else $error("link active not shown");
	link_lo_a:
		assert property (!dl_active |=> !link_active)
		else $error("link active while not active");
	dll_flag_a:
		assert property (dl_active != link_active |=> dllsc_flag)
		else $error("state change flag not set");
	dll_clr_a:
		assert property (dllsc_clr && dl_active == link_active |=> !dllsc_flag)
		else $error("state change flag not cleared");
	dll_hold_a:
		assert property (dllsc_flag && !dllsc_clr |=> dllsc_flag)
		else $error("state change flag lost");

	cmd_path_a:
		assert property (ev_cmd && q.ctl[CTL_CC] && q.ctl[CTL_HPIE] |=> hp_int)
		else $error("command done interrupt lost");
	cmd_nowake_a:
		assert property (ev_cmd && !ev_abtn && !ev_pfault && !ev_pdc |=> !wake)
		else $error("command done raised wake");
	wake_free_a:
		assert property (ev_abtn && q.ctl[CTL_ABP] && !q.ctl[CTL_HPIE] |=> wake && !hp_int)
		else $error("button wake gated wrongly");
	wake_cause_a:
		assert property (wake |-> $past(ev_abtn && q.ctl[CTL_ABP] || ev_pfault && q.ctl[CTL_PFD]
			|| ev_pdc && q.ctl[CTL_PDC]))
		else $error("wake without enabled event");
	// Every interrupt must trace back to the master gate and one enabled source
	irq_cause_a:
		assert property (hp_int |-> $past(q.ctl[CTL_HPIE] && (ev_abtn && q.ctl[CTL_ABP]
			|| ev_pfault && q.ctl[CTL_PFD] || ev_pdc && q.ctl[CTL_PDC]
			|| ev_cmd && q.ctl[CTL_CC] || dl_active != link_active && q.ctl[CTL_DLL])))
		else $error("interrupt without enabled event");

	// A new offer: idle before, or the previous one just taken
	sequence launch_s;
		msg_valid && (!$past(msg_valid) || $past(msg_ready));
	endsequence
	plim_msg_a:
		assert property (launch_s ##0 (msg_code == MSG_SPL)
			|-> msg_data == $past(q.cap[CAP_PLV +: 10]))
		else $error("limit message payload wrong");
	attn_code_a:
		assert property (launch_s ##0 ((msg_code & 8'hfc) == MSG_ATTN)
			|-> (msg_code == (MSG_ATTN | MSG_ON)) == ($past(attn_ind) == IND_ON)
			&& (msg_code == (MSG_ATTN | MSG_BLINK)) == ($past(attn_ind) == IND_BLINK))
		else $error("attention message code wrong");
	pind_code_a:
		assert property (launch_s ##0 ((msg_code & 8'hfc) == MSG_PWR)
			|-> (msg_code == (MSG_PWR | MSG_ON)) == ($past(pwr_ind) == IND_ON)
			&& (msg_code == (MSG_PWR | MSG_BLINK)) == ($past(pwr_ind) == IND_BLINK))
		else $error("power indicator message code wrong");

	unmap_wr_a:
		assert property (cfg_wr && !cap_hit && !ctl_hit && !ld_wr
			|=> $stable(q.cap) && $stable(q.ctl))
		else $error("unmapped write changed state");
	unmap_rd_a:
		assert property (cfg_rd && !cap_hit && !ctl_hit
			|=> cfg_rvalid && cfg_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	rvalid_a:
		assert property (cfg_rd |=> cfg_rvalid)
		else $error("read not answered");
endmodule : slot_hp_regs

// File: bench/slot_hp_regs_tb_top.sv
module slot_hp_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import slot_hp_pkg::*;

	logic mclk;
	logic rst_n;
	logic cfg_wr;
	logic cfg_rd;
	addr_t cfg_addr;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata;
	logic [31:0] cfg_rdata;
	logic cfg_rvalid;
	logic ld_wr;
	logic [31:0] ld_data;
	logic [3:0] ev;
	logic dl_active;
	logic dllsc_clr;
	logic msg_ready;
	logic msg_valid;
	logic [7:0] msg_code;
	logic [9:0] msg_data;
	logic hp_int;
	logic wake;
	logic link_active;
	logic dllsc_flag;
	logic [1:0] attn_ind;
	logic [1:0] pwr_ind;
	logic slot_power_off;
	int errors;
	int cmp_count;

	slot_hp_regs u_slot_hp_regs (
		.mclk(mclk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.ld_wr(ld_wr), .ld_data(ld_data), .ev_abtn(ev[0]), .ev_pfault(ev[1]), .ev_pdc(ev[2]),
		.ev_cmd(ev[3]), .dl_active(dl_active), .dllsc_clr(dllsc_clr), .msg_ready(msg_ready),
		.msg_valid(msg_valid), .msg_code(msg_code), .msg_data(msg_data), .hp_int(hp_int),
		.wake(wake), .link_active(link_active), .dllsc_flag(dllsc_flag), .attn_ind(attn_ind),
		.pwr_ind(pwr_ind), .slot_power_off(slot_power_off)
	);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Inputs always move 1 ns after the rising edge, so sampling never races
	task automatic tick();
		@(posedge mclk);
		#1;
	endtask : tick

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic cfg_write(input addr_t a, input logic [3:0] be, input logic [31:0] d);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		tick();
		cfg_wr = 1'b0;
	endtask : cfg_write

	task automatic cfg_read(input addr_t a, input logic [31:0] exp, input string name);
		cfg_rd = 1'b1;
		cfg_addr = a;
		tick();
		cfg_rd = 1'b0;
		check({name, " rvalid"}, 32'(cfg_rvalid), 32'h1);
		check(name, cfg_rdata, exp);
	endtask : cfg_read

	// Stalls two cycles first so the offer must hold steady under back-pressure
	task automatic take_msg(input logic [7:0] code, input logic [9:0] data);
		int n;
		n = 0;
		while (msg_valid !== 1'b1 && n < 20) begin
			tick();
			n++;
		end
		if (n == 20) begin
			errors++;
			$display("mismatch msg_valid expected 1 seen timeout");
			results();
		end
		tick();
		tick();
		check("msg_valid held", 32'(msg_valid), 32'h1);
		check("msg_code", 32'(msg_code), 32'(code));
		check("msg_data", 32'(msg_data), 32'(data));
		msg_ready = 1'b1;
		tick();
		msg_ready = 1'b0;
	endtask : take_msg

	task automatic no_msg(input int cycles);
		repeat (cycles) begin
			tick();
			check("msg_valid idle", 32'(msg_valid), 32'h0);
		end
	endtask : no_msg

	task automatic test_reset();
		cfg_read(CAP_OFS, 32'h0000_0000, "cap reset");
		// Idle edge so the read strobe is not dropped and raised in one step
		tick();
		cfg_read(CTL_OFS, 32'h0000_03c0, "ctl reset");
		check("attn_ind reset", 32'(attn_ind), 32'h3);
		check("pwr_ind reset", 32'(pwr_ind), 32'h3);
		check("power_off reset", 32'(slot_power_off), 32'h0);
		$display("test reset done");
	endtask : test_reset

	task automatic test_cap_write();
		cfg_write(CAP_OFS, 4'hf, 32'hffff_ffff);
		take_msg(8'h50, 10'h3ff);
		cfg_read(CAP_OFS, 32'h0001_ff80, "cap ro bits");
		// Lane 0 alone carries only the low bit of the limit value
		cfg_write(CAP_OFS, 4'h1, 32'h0000_0000);
		take_msg(8'h50, 10'h3fe);
		cfg_read(CAP_OFS, 32'h0001_ff00, "cap partial");
		cfg_write(12'h0dc, 4'hf, 32'hffff_ffff);
		no_msg(4);
		cfg_read(12'h0dc, 32'h0000_0000, "unmapped");
		$display("test cap_write done");
	endtask : test_cap_write

	task automatic test_loader();
		ld_data = 32'hffff_ffff;
		ld_wr = 1'b1;
		tick();
		ld_wr = 1'b0;
		no_msg(4);
		cfg_read(CAP_OFS, 32'hfff9_fffb, "cap loaded");
		ld_data = 32'h0000_0000;
		ld_wr = 1'b1;
		tick();
		ld_wr = 1'b0;
		cfg_read(CAP_OFS, 32'h0000_0000, "cap reloaded");
		$display("test loader done");
	endtask : test_loader

	task automatic test_ctl_write();
		logic [1:0] c;
		cfg_write(CTL_OFS, 4'hf, 32'hffff_ffff);
		take_msg(8'h40, 10'h000);
		take_msg(8'h44, 10'h000);
		cfg_read(CTL_OFS, 32'h0000_17fb, "ctl all ones");
		check("power_off set", 32'(slot_power_off), 32'h1);
		for (int i = 1; i < 3; i++) begin
			c = 2'(i);
			cfg_write(CTL_OFS, 4'h3, {22'h0, c, c, 6'h0});
			take_msg(i == 1 ? 8'h41 : 8'h43, 10'h000);
			take_msg(i == 1 ? 8'h45 : 8'h47, 10'h000);
			check("attn_ind", 32'(attn_ind), 32'(c));
			check("pwr_ind", 32'(pwr_ind), 32'(c));
		end
		cfg_write(CTL_OFS, 4'h3, 32'h0000_0000);
		no_msg(4);
		check("power_off clear", 32'(slot_power_off), 32'h0);
		$display("test ctl_write done");
	endtask : test_ctl_write

	task automatic pulse_ev(input int k, input logic exp_int, input logic exp_wake);
		ev = 4'h1 << k;
		tick();
		ev = 4'h0;
		check("hp_int", 32'(hp_int), 32'(exp_int));
		check("wake", 32'(wake), 32'(exp_wake));
		tick();
		check("hp_int drop", 32'(hp_int), 32'h0);
	endtask : pulse_ev

	task automatic test_events();
		cfg_write(CTL_OFS, 4'h3, 32'h0000_103b);
		for (int k = 0; k < 4; k++) pulse_ev(k, 1'b1, k < 3);
		// Enables without the master gate: wake still allowed, no interrupt
		cfg_write(CTL_OFS, 4'h3, 32'h0000_001b);
		for (int k = 0; k < 4; k++) pulse_ev(k, 1'b0, k < 3);
		cfg_write(CTL_OFS, 4'h3, 32'h0000_0020);
		for (int k = 0; k < 4; k++) pulse_ev(k, 1'b0, 1'b0);
		$display("test events done");
	endtask : test_events

	task automatic link_step(input logic lvl, input logic exp_int);
		logic seen;
		dl_active = lvl;
		tick();
		seen = hp_int;
		check("link_active", 32'(link_active), 32'(lvl));
		check("dllsc_flag set", 32'(dllsc_flag), 32'h1);
		repeat (3) begin
			tick();
			seen = seen | hp_int;
		end
		check("link hp_int", 32'(seen), 32'(exp_int));
		dllsc_clr = 1'b1;
		tick();
		dllsc_clr = 1'b0;
		check("dllsc_flag clr", 32'(dllsc_flag), 32'h0);
	endtask : link_step

	task automatic test_link();
		cfg_write(CTL_OFS, 4'h3, 32'h0000_1020);
		link_step(1'b1, 1'b1);
		cfg_write(CTL_OFS, 4'h3, 32'h0000_0020);
		link_step(1'b0, 1'b0);
		$display("test link done");
	endtask : test_link

	// Indicators, power command and a pending message must all fall back on a mid-run reset
	task automatic test_mid_reset();
		cfg_write(CTL_OFS, 4'h3, 32'h0000_0740);
		rst_n = 1'b0;
		tick();
		rst_n = 1'b1;
		check("msg_valid reset", 32'(msg_valid), 32'h0);
		tick();
		test_reset();
		$display("test mid_reset done");
	endtask : test_mid_reset

	initial begin
		errors = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = 12'h000;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
		ld_wr = 1'b0;
		ld_data = 32'h0;
		ev = 4'h0;
		dl_active = 1'b0;
		dllsc_clr = 1'b0;
		msg_ready = 1'b0;
		repeat (16) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		tick();
		test_reset();
		test_cap_write();
		test_loader();
		test_ctl_write();
		test_events();
		test_link();
		test_mid_reset();
		results();
	end
endmodule : slot_hp_regs_tb_top
